// file: verilog/uart_rx_defs.svh
// How it works
// RULE1: x16 oversampling, shifter advances per bit.
// RULE2: Frames accepted only while receive enable set.
// RULE3: After stop bit, word moves into FIFO.
// RULE4: Transfer into FIFO sets receive flag.
// RULE5: Receive flag interrupts only when enabled.
// RULE6: Flag read-only, clears when FIFO empty.
// RULE7: Two-entry FIFO plus word in shifter.
// RULE8: Stop bit while full sets overrun, drops.
// RULE9: Overrun sticky; cleared by toggling receive enable.
// RULE10: Overrun blocks all transfers into FIFO.
// RULE11: Low stop bit sets framing error.
// RULE12: Framing and ninth bit queued per entry.
// RULE13: Software reads status before reading data.
// RULE14: Address match drops words with ninth bit 0.
// RULE15: Address match acts only in nine-bit mode.
// RULE16: Address match off receives every word.
// RULE17: Divider rate is clock over 4(divisor+1).
// RULE18: Falling idle line starts frame assembly.
`ifndef UART_RX_DEFS_SVH
`define UART_RX_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_RX_STATUS_CTRL 5'h00
`define OFS_BAUD_DIVISOR   5'h04
`define OFS_RX_DATA_FIFO   5'h08
`define OFS_PERIPH_FLAG    5'h0c
`define OFS_PERIPH_IRQ_EN  5'h10
`define OFS_EVENT_STATUS   5'h14
`define OFS_EVENT_MASK     5'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_NINE_BIT_SEL   6
`define BIT_CONT_RX_EN     4
`define BIT_ADDR_MATCH_EN  3
`define BIT_FRAMING_ERR    2
`define BIT_OVERRUN_ERR    1
`define BIT_NINTH_BIT      0
`define BIT_RECEIVE_FLAG   5
`define BIT_RECEIVE_IRQ_EN 5
`define EVT_WORD_RECEIVED  0
`define EVT_OVERRUN        1
`define EVT_FRAMING        2

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RST_BAUD_DIVISOR   8'h00
`define RST_EVENT_MASK     3'h0
`define PRESCALE_LAST      2'h3
`define OVERSAMPLE_LAST    4'hf
`define START_CENTRE       4'h7
`define LAST_BIT_8         4'h7
`define LAST_BIT_9         4'h8

`endif

// file: verilog/uart_rx_pkg.sv
package uart_rx_pkg;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage

// file: verilog/rx_oversampler.sv
`timescale 1ns/1ps
`include "uart_rx_defs.svh"
module rx_oversampler
    import uart_rx_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rstn,
    // Control
    input  wire logic       i_enable,
    input  wire logic [7:0] i_divisor,
    // Sample tick
    output logic            o_tick
);
    logic [1:0] pre_reg;
    logic [7:0] cnt_reg;

    // ----------------------------------------
    // Divider: one tick per 4*(divisor+1) clocks
    // ----------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn || !i_enable)
        begin
            pre_reg <= 2'h0;
            cnt_reg <= 8'h00;
            o_tick  <= 1'b0;
        end
        else
        begin
            pre_reg <= pre_reg + 2'h1; // [RULE17]
            o_tick  <= 1'b0;
            if (pre_reg == `PRESCALE_LAST)
            begin
                // Comparing with >= lets a smaller divisor act at once instead of after a full wrap.
                if (cnt_reg >= i_divisor)
                begin
                    cnt_reg <= 8'h00;
                    o_tick  <= 1'b1; // [RULE1]
                end
                else
                begin
                    cnt_reg <= cnt_reg + 8'h01;
                end
            end
        end
    end

    property p_tick_spacing;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        o_tick |=> !o_tick;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("sample tick lasted more than one cycle"); // [RULE17]
endmodule // rx_oversampler

// file: verilog/async_serial_receiver.sv
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "uart_rx_defs.svh"
module async_serial_receiver
    import uart_rx_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    // Avalon-MM slave
    input  wire logic [4:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    // Serial line and interrupt
    input  wire logic        i_serial_input_pin,
    output logic             o_irq
);
    rx_state_t   state_reg;
    logic [3:0]  scnt_reg;
    logic [3:0]  bitcnt_reg;
    logic [8:0]  receive_shift_register;
    logic        sample_tick;
    logic        nine_bit_receive_select;
    logic        continuous_receive_enable;
    logic        address_match_enable;
    logic        overrun_error;
    logic        receive_irq_enable;
    logic [7:0]  baud_divisor;
    logic [2:0]  event_status_reg;
    logic [2:0]  event_mask_reg;
    logic [9:0]  receive_data_fifo [2];
    logic        wr_ptr_reg;
    logic        rd_ptr_reg;
    logic [1:0]  count_reg;
    logic        frame_done;
    logic        addr_drop;
    logic        fifo_full;
    logic        push;
    logic        pop;
    logic        set_overrun;
    logic        stop_low;
    logic        acc;
    logic        receive_flag;
    logic [9:0]  head;
    logic [2:0]  event_set;
    logic [2:0]  event_clr;
    logic [31:0] readdata_next;

    rx_oversampler u_oversampler
    (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_enable  (continuous_receive_enable),
        .i_divisor (baud_divisor),
        .o_tick    (sample_tick)
    );

    // ----------------------------------------
    // Bus access
    // ----------------------------------------
    assign acc          = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
    assign pop          = acc && i_avs_read && (i_avs_address == `OFS_RX_DATA_FIFO) && (count_reg != 2'h0);
    assign receive_flag = (count_reg != 2'h0); // [RULE6]
    assign head         = receive_data_fifo[rd_ptr_reg];

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
            o_avs_waitrequest <= 1'b1;
        else
            o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
    end

    always_comb
    begin
        readdata_next = 32'h0000_0000;
        unique case (i_avs_address)
            `OFS_RX_STATUS_CTRL:
            begin
                readdata_next[`BIT_NINE_BIT_SEL]  = nine_bit_receive_select;
                readdata_next[`BIT_CONT_RX_EN]    = continuous_receive_enable;
                readdata_next[`BIT_ADDR_MATCH_EN] = address_match_enable;
                readdata_next[`BIT_FRAMING_ERR]   = head[9] && receive_flag; // [RULE12]
                readdata_next[`BIT_OVERRUN_ERR]   = overrun_error;
                readdata_next[`BIT_NINTH_BIT]     = head[8] && receive_flag;
            end
            `OFS_BAUD_DIVISOR:  readdata_next[7:0] = baud_divisor;
            `OFS_RX_DATA_FIFO:  readdata_next[7:0] = receive_flag ? head[7:0] : 8'h00;
            `OFS_PERIPH_FLAG:   readdata_next[`BIT_RECEIVE_FLAG] = receive_flag;
            `OFS_PERIPH_IRQ_EN: readdata_next[`BIT_RECEIVE_IRQ_EN] = receive_irq_enable;
            `OFS_EVENT_STATUS:  readdata_next[2:0] = event_status_reg;
            `OFS_EVENT_MASK:    readdata_next[2:0] = event_mask_reg;
            default:            readdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
            o_avs_readdata <= 32'h0000_0000;
        else if (i_avs_read && o_avs_waitrequest)
            o_avs_readdata <= readdata_next;
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            nine_bit_receive_select   <= 1'b0;
            continuous_receive_enable <= 1'b0;
            address_match_enable      <= 1'b0;
            baud_divisor              <= `RST_BAUD_DIVISOR;
            receive_irq_enable        <= 1'b0;
            event_mask_reg            <= `RST_EVENT_MASK;
        end
        else if (acc && i_avs_write)
        begin
            unique case (i_avs_address)
                `OFS_RX_STATUS_CTRL:
                begin
                    nine_bit_receive_select   <= i_avs_writedata[`BIT_NINE_BIT_SEL];
                    continuous_receive_enable <= i_avs_writedata[`BIT_CONT_RX_EN];
                    address_match_enable      <= i_avs_writedata[`BIT_ADDR_MATCH_EN];
                end
                `OFS_BAUD_DIVISOR:  baud_divisor <= i_avs_writedata[7:0];
                `OFS_PERIPH_IRQ_EN: receive_irq_enable <= i_avs_writedata[`BIT_RECEIVE_IRQ_EN];
                `OFS_EVENT_MASK:    event_mask_reg <= i_avs_writedata[2:0];
                default:            ;
            endcase
        end
    end

    // ----------------------------------------
    // Frame recovery
    // ----------------------------------------
    // Sampling at the bit centre keeps one sample per bit; the line is not majority-voted.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn || !continuous_receive_enable) // [RULE2] [RULE9]
        begin
            state_reg              <= RX_IDLE;
            scnt_reg               <= 4'h0;
            bitcnt_reg             <= 4'h0;
            receive_shift_register <= 9'h000;
        end
        else
        begin
            unique case (state_reg)
                RX_IDLE:
                begin
                    scnt_reg               <= 4'h0;
                    bitcnt_reg             <= 4'h0;
                    receive_shift_register <= 9'h000;
                    if (!i_serial_input_pin)
                        state_reg <= RX_START; // [RULE18]
                end
                RX_START:
                begin
                    if (sample_tick)
                    begin
                        scnt_reg <= scnt_reg + 4'h1;
                        if (scnt_reg == `START_CENTRE)
                        begin
                            scnt_reg  <= 4'h0;
                            state_reg <= i_serial_input_pin ? RX_IDLE : RX_DATA; // [RULE18]
                        end
                    end
                end
                RX_DATA:
                begin
                    if (sample_tick)
                    begin
                        scnt_reg <= scnt_reg + 4'h1;
                        if (scnt_reg == `OVERSAMPLE_LAST)
                        begin
                            receive_shift_register[bitcnt_reg] <= i_serial_input_pin; // [RULE1]
                            bitcnt_reg <= bitcnt_reg + 4'h1;
                            if (bitcnt_reg == (nine_bit_receive_select ? `LAST_BIT_9 : `LAST_BIT_8))
                                state_reg <= RX_STOP;
                        end
                    end
                end
                RX_STOP:
                begin
                    if (sample_tick)
                    begin
                        scnt_reg <= scnt_reg + 4'h1;
                        if (scnt_reg == `OVERSAMPLE_LAST)
                            state_reg <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // Transfer decision
    // ----------------------------------------
    assign frame_done  = continuous_receive_enable && (state_reg == RX_STOP) && sample_tick
                         && (scnt_reg == `OVERSAMPLE_LAST);
    assign stop_low    = !i_serial_input_pin; // [RULE11]
    assign addr_drop   = nine_bit_receive_select && address_match_enable
                         && !receive_shift_register[8]; // [RULE14] [RULE15] [RULE16]
    assign fifo_full   = (count_reg == 2'h2) && !pop; // [RULE7]
    assign push        = frame_done && !addr_drop && !overrun_error && !fifo_full; // [RULE3] [RULE10]
    assign set_overrun = frame_done && !addr_drop && !overrun_error && fifo_full; // [RULE8]

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn || !continuous_receive_enable)
            overrun_error <= 1'b0; // [RULE9]
        else if (set_overrun)
            overrun_error <= 1'b1;
    end

    // ----------------------------------------
    // Receive FIFO
    // ----------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (push)
            receive_data_fifo[wr_ptr_reg] <= {stop_low, receive_shift_register}; // [RULE12]
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= !wr_ptr_reg;
            if (pop)
                rd_ptr_reg <= !rd_ptr_reg; // [RULE12]
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop}; // [RULE4] [RULE6]
        end
    end

    // ----------------------------------------
    // Events and interrupt
    // ----------------------------------------
    assign event_set = {frame_done && stop_low, set_overrun, push};
    assign event_clr = (acc && i_avs_write && (i_avs_address == `OFS_EVENT_STATUS)) ?
                       i_avs_writedata[2:0] : 3'h0;

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
            event_status_reg <= 3'h0;
        else
            event_status_reg <= (event_status_reg & ~event_clr) | event_set;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
            o_irq <= 1'b0;
        else
            o_irq <= (receive_flag && receive_irq_enable) || |(event_status_reg & event_mask_reg); // [RULE5]
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_rx_enable;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        !continuous_receive_enable |=> (state_reg == RX_IDLE) && !overrun_error;
    endproperty
    a_rx_enable: assert property (p_rx_enable) else $error("receiver ran while disabled"); // [RULE2]

    property p_push_flag;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        push |=> receive_flag;
    endproperty
    a_push_flag: assert property (p_push_flag) else $error("flag not set after transfer"); // [RULE4]

    property p_irq_gate;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        o_irq |-> $past(receive_flag && receive_irq_enable) || $past(|(event_status_reg & event_mask_reg));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enabled cause"); // [RULE5]

    property p_flag_clear;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        pop && (count_reg == 2'h1) && !push |=> !receive_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag stayed after FIFO emptied"); // [RULE6]

    property p_fifo_depth;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        count_reg <= 2'h2;
    endproperty
    a_fifo_depth: assert property (p_fifo_depth) else $error("FIFO above two entries"); // [RULE7]

    property p_overrun;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        frame_done && !addr_drop && (count_reg == 2'h2) && !pop ##1 continuous_receive_enable
        |-> overrun_error && (count_reg == 2'h2);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // [RULE8]

    property p_overrun_sticky;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        overrun_error ##1 continuous_receive_enable |-> overrun_error;
    endproperty
    a_overrun_sticky: assert property (p_overrun_sticky) else $error("overrun cleared by itself"); // [RULE9]

    property p_block;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        overrun_error |-> !push ##1 ($stable(wr_ptr_reg) || !overrun_error);
    endproperty
    a_block: assert property (p_block) else $error("transfer during overrun"); // [RULE10]

    property p_address_drop;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        frame_done && nine_bit_receive_select && address_match_enable && !receive_shift_register[8]
        |=> $stable(wr_ptr_reg) && !event_status_reg[`EVT_OVERRUN] || $past(event_status_reg[`EVT_OVERRUN]);
    endproperty
    a_address_drop: assert property (p_address_drop) else $error("data word loaded under address match"); // [RULE14]

    property p_start;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (state_reg == RX_IDLE) && continuous_receive_enable && !i_serial_input_pin |=> state_reg == RX_START;
    endproperty
    a_start: assert property (p_start) else $error("falling line did not start a frame"); // [RULE18]

    c_push:     cover property (@(posedge i_clk_sys) disable iff (!i_rstn) push);
    c_overrun:  cover property (@(posedge i_clk_sys) disable iff (!i_rstn) set_overrun);
    c_drop:     cover property (@(posedge i_clk_sys) disable iff (!i_rstn) frame_done && addr_drop);
    c_pop_full: cover property (@(posedge i_clk_sys) disable iff (!i_rstn) pop && (count_reg == 2'h2));
endmodule // async_serial_receiver

// file: dv/serial_tx_model.sv
`timescale 1ns/1ps
module serial_tx_model
(
    // Clock
    input  wire logic i_clk_sys,
    // Serial line
    output logic      o_line
);
    // ----------------------------------------
    // Frame generator
    // ----------------------------------------
    initial o_line = 1'b1;

    task automatic hold(input logic v, input int n);
        o_line <= v;
        repeat (n) @(posedge i_clk_sys);
    endtask

    // A broken stop bit is released early to idle high, so that the receiver, which takes
    // the tail of it as a start bit, finds the line high at the start centre and returns to idle.
    task automatic send(input logic [8:0] w, input int nbits, input logic stop_ok, input int clks);
        hold(1'b0, clks);
        for (int i = 0; i < nbits; i++)
            hold(w[i], clks);
        if (stop_ok)
            hold(1'b1, clks);
        else
            hold(1'b0, clks * 3 / 4);
        hold(1'b1, 2 * clks);
    endtask
endmodule // serial_tx_model

// file: dv/async_serial_receiver_bench.sv
`timescale 1ns/1ps
`include "uart_rx_defs.svh"
module async_serial_receiver_bench;
    logic        clk     = 1'b0;
    logic        rstn    = 1'b0;
    logic [4:0]  address = 5'h00;
    logic        read    = 1'b0;
    logic        write   = 1'b0;
    logic [31:0] wdata   = 32'h0;
    logic [31:0] rdata;
    logic        waitreq;
    logic        line;
    logic        irq;
    int          n_mismatch = 0;
    int          cmp_count  = 0;

    async_serial_receiver uut
    (
        .i_clk_sys          (clk),
        .i_rstn             (rstn),
        .i_avs_address      (address),
        .i_avs_read         (read),
        .i_avs_write        (write),
        .i_avs_writedata    (wdata),
        .o_avs_readdata     (rdata),
        .o_avs_waitrequest  (waitreq),
        .i_serial_input_pin (line),
        .o_irq              (irq)
    );

    serial_tx_model tx
    (
        .i_clk_sys (clk),
        .o_line    (line)
    );

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Values read right after an edge are those sampled at it, since the
    // design updates by non-blocking assignment.
    task automatic access(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        address <= a;
        wdata <= d;
        read <= !wr;
        write <= wr;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitreq !== 1'b0 && n < 50);
        check({31'h0, waitreq}, 32'h0);
        q = rdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        access(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        access(1'b1, a, d, q);
    endtask

    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, {31'h0, exp});
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd_chk(`OFS_RX_STATUS_CTRL, 32'h0);
        rd_chk(`OFS_PERIPH_FLAG, 32'h0);
        rd_chk(5'h1c, 32'h0);
        rd_chk(`OFS_RX_DATA_FIFO, 32'h0);
        wr(`OFS_BAUD_DIVISOR, 32'h5a);
        rd_chk(`OFS_BAUD_DIVISOR, 32'h5a);
        wr(`OFS_BAUD_DIVISOR, 32'h1);
        tx.send(9'h0a5, 8, 1'b1, 128);
        rd_chk(`OFS_PERIPH_FLAG, 32'h0);
        wr(`OFS_PERIPH_IRQ_EN, 32'h20);
        wr(`OFS_RX_STATUS_CTRL, 32'h10);
        tx.send(9'h0a5, 8, 1'b1, 128);
        rd_chk(`OFS_PERIPH_FLAG, 32'h20);
        irq_chk(1'b1);
        wr(`OFS_PERIPH_FLAG, 32'h0);
        rd_chk(`OFS_PERIPH_FLAG, 32'h20);
        wr(`OFS_PERIPH_IRQ_EN, 32'h0);
        irq_chk(1'b0);
        rd_chk(`OFS_RX_STATUS_CTRL, 32'h10);
        rd_chk(`OFS_RX_DATA_FIFO, 32'ha5);
        rd_chk(`OFS_PERIPH_FLAG, 32'h0);
        // Four words into a two-entry store: third overruns, fourth is blocked.
        wr(`OFS_BAUD_DIVISOR, 32'h0);
        for (int i = 1; i <= 4; i++)
            tx.send(9'(8'h11 * i), 8, 1'b1, 64);
        rd_chk(`OFS_RX_STATUS_CTRL, 32'h12);
        rd_chk(`OFS_RX_DATA_FIFO, 32'h11);
        rd_chk(`OFS_RX_DATA_FIFO, 32'h22);
        rd_chk(`OFS_PERIPH_FLAG, 32'h0);
        rd_chk(`OFS_RX_STATUS_CTRL, 32'h12);
        wr(`OFS_RX_STATUS_CTRL, 32'h0);
        wr(`OFS_RX_STATUS_CTRL, 32'h10);
        rd_chk(`OFS_RX_STATUS_CTRL, 32'h10);
        tx.send(9'h055, 8, 1'b1, 64);
        rd_chk(`OFS_RX_DATA_FIFO, 32'h55);
        rd_chk(`OFS_EVENT_STATUS, 32'h3);
        wr(`OFS_EVENT_STATUS, 32'h3);
        rd_chk(`OFS_EVENT_STATUS, 32'h0);
        wr(`OFS_EVENT_MASK, 32'h4);
        // Nine-bit words: status bits travel with each stored word.
        wr(`OFS_RX_STATUS_CTRL, 32'h50);
        tx.send(9'h13c, 9, 1'b0, 64);
        tx.send(9'h0c3, 9, 1'b1, 64);
        rd_chk(`OFS_EVENT_STATUS, 32'h5);
        irq_chk(1'b1);
        wr(`OFS_EVENT_STATUS, 32'h4);
        irq_chk(1'b0);
        rd_chk(`OFS_RX_STATUS_CTRL, 32'h55);
        rd_chk(`OFS_RX_DATA_FIFO, 32'h3c);
        rd_chk(`OFS_RX_STATUS_CTRL, 32'h50);
        rd_chk(`OFS_RX_DATA_FIFO, 32'hc3);
        // Address matching, then the same enable without nine-bit mode.
        wr(`OFS_RX_STATUS_CTRL, 32'h58);
        tx.send(9'h011, 9, 1'b1, 64);
        rd_chk(`OFS_PERIPH_FLAG, 32'h0);
        tx.send(9'h122, 9, 1'b1, 64);
        rd_chk(`OFS_RX_STATUS_CTRL, 32'h59);
        rd_chk(`OFS_RX_DATA_FIFO, 32'h22);
        wr(`OFS_RX_STATUS_CTRL, 32'h18);
        tx.send(9'h033, 8, 1'b1, 64);
        rd_chk(`OFS_RX_DATA_FIFO, 32'h33);
        results();
    end

    // The sequence needs some 11000 cycles; the limit leaves ample margin.
    initial
    begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        $display("Error at %0t: watchdog, got %h expected %h", $time, 32'h1, 32'h0);
        results();
    end
endmodule // async_serial_receiver_bench
